// *** pss_pkg.sv ***
package pss_pkg;

   // Command codes of the status commands served by this block.
   localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;

   // Bit positions in the summary byte.
   localparam int SB_OFF = 6;
   localparam int SB_OVF = 5;
   localparam int SB_OCF = 4;
   localparam int SB_TEMP = 2;
   localparam int SB_CML = 1;
   localparam int SB_OTHER = 0;

   // Bit positions in the high byte of the summary word.
   localparam int SW_VOUT = 7;
   localparam int SW_IOUT = 6;
   localparam int SW_INPUT = 5;
   localparam int SW_VENDOR = 4;
   localparam int SW_PNG = 3;

   // Output-voltage flags occupy bits 7 down to 2 of their byte.
   localparam int VOUT_NFLAGS = 6;
   localparam int VOUT_LSB = 2;
   localparam int VF_OVF = 5;
   localparam int VF_OVW = 4;
   localparam int VF_UVW = 3;
   localparam int VF_UVF = 2;
   localparam int VF_SETPT = 1;
   localparam int VF_TONTO = 0;

   // Alert source vector layout.
   localparam int AS_NSRC = 11;

   // Values after reset, and response lengths.
   localparam logic [5:0] VOUT_RST = 6'h00;
   localparam logic [0:0] INUV_RST = 1'h1;
   localparam logic PNG_MASK_RST = 1'h1;
   localparam logic [1:0] LEN_BYTE = 2'h1;
   localparam logic [1:0] LEN_WORD = 2'h2;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [7:0] wdata;
   } pss_cmd_s;

   typedef struct packed {
      logic valid;
      logic err;
      logic [1:0] len;
      logic [15:0] data;
   } pss_rsp_s;

   typedef struct packed {
      logic conv_enabled;
      logic iout_fault;
      logic iout_warn;
      logic temp_any;
      logic cml_any;
      logic input_other;
      logic mfr_overtemp;
      logic mfr_vout_min;
      logic power_bad;
   } pss_src_s;

endpackage

// *** pss_w1c_flags.sv ***
module pss_w1c_flags
   import pss_pkg::*;
#(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] set_evt,
   input wire logic clr_stb,
   input wire logic [W-1:0] clr_bits,
   output logic [W-1:0] flags_ff
);

   // A flag raised in the cycle of its clear stays set, so no event is lost.
   for (genvar i = 0; i < W; i++) begin : g_flag
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            flags_ff[i] <= RST[i];
         end else if (set_evt[i]) begin
            flags_ff[i] <= 1'b1;
         end else if (clr_stb && clr_bits[i]) begin
            flags_ff[i] <= 1'b0;
         end
      end
   end

endmodule // pss_w1c_flags

// *** pss_alert.sv ***
module pss_alert
   import pss_pkg::*;
#(
   parameter int W = AS_NSRC
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] src,
   input wire logic [W-1:0] mask,
   output logic alert_ff
);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         alert_ff <= 1'b0;
      end else begin
         alert_ff <= |(src & ~mask);
      end
   end

endmodule // pss_alert

// *** pss_status.sv ***
// Operation
// - Command 78h read returns one read-only summary byte of critical faults.
// - Summary bit 6 reads 1 whenever the converter is not enabled.
// - Summary bit 5 mirrors the output overvoltage fault flag.
// - Summary bit 4 mirrors the output overcurrent fault flag.
// - Alert masking uses only source masks; summary bits have none.
// - Summary bits ignore writes and clear only when sources clear.
// - Summary bit 2 is set when any temperature source flag is set.
// - Summary bit 1 is set when any communication/memory/logic flag is set.
// - Summary bit 0 covers other faults and warnings, e.g. undervoltage.
// - Summary bit 0 reads 1 after reset via the input undervolt flag.
// - Command 79h returns two bytes; low byte equals the summary byte.
// - Word high byte: vout, iout, input, vendor, power_not_good at 7..3.
// - vout_summary is the OR of all output-voltage source flags.
// - iout_summary is set for overcurrent fault or warning.
// - Input summary is set while any input flag is present.
// - vendor_fault_summary is set for internal overtemp or output minimum.
// - power_not_good is unlatched and tracks the present condition.
// - The power_not_good alert mask resets to 1.
// - Command 7Ah returns output-voltage flags at bits 7..2, reset zero.
// - Output-voltage flags clear by host write; stored bits raise alerts unless masked by vout_mask.
module pss_status
   import pss_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input pss_cmd_s cmd,
   input pss_src_s src,
   input wire logic [VOUT_NFLAGS-1:0] vout_evt,
   input wire logic [VOUT_NFLAGS-1:0] vout_mask,
   input wire logic [1:0] iout_mask,
   input wire logic vin_low_evt,
   input wire logic inuv_clr,
   input wire logic inuv_mask,
   input wire logic ext_alert,
   input wire logic png_mask_wr,
   input wire logic png_mask_val,
   output pss_rsp_s rsp_ff,
   output logic [7:0] vout_status_ff,
   output logic alert_ff
);

   logic [VOUT_NFLAGS-1:0] vout_flags;
   logic [0:0] inuv_flag;
   logic png_mask_ff;
   logic vout_clr;
   logic [7:0] status_byte;
   logic [7:0] word_high;
   logic input_any;
   logic vout_any;
   logic [AS_NSRC-1:0] alert_src;
   logic [AS_NSRC-1:0] alert_mask;
   pss_rsp_s nxt_rsp;

   function automatic logic is_read(input pss_cmd_s c, input logic [7:0] code);
      return c.valid && !c.write && (c.code == code);
   endfunction

   // Only a write to the output-voltage status command clears flags;
   // writes to either summary command fall through without effect.
   assign vout_clr = cmd.valid && cmd.write && (cmd.code == CMD_OUTPUT_VOLTAGE_STATUS);

   pss_w1c_flags #(
      .W(VOUT_NFLAGS),
      .RST(VOUT_RST)
   ) u_vout_flags (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_evt(vout_evt),
      .clr_stb(vout_clr),
      .clr_bits(cmd.wdata[7:VOUT_LSB]),
      .flags_ff(vout_flags)
   );

   // The input undervoltage flag starts set, since the input has not been
   // qualified yet when the core leaves reset.
   pss_w1c_flags #(
      .W(1),
      .RST(INUV_RST)
   ) u_inuv_flag (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_evt(vin_low_evt),
      .clr_stb(inuv_clr),
      .clr_bits(1'b1),
      .flags_ff(inuv_flag)
   );

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         png_mask_ff <= PNG_MASK_RST;
      end else if (png_mask_wr) begin
         png_mask_ff <= png_mask_val;
      end
   end

   // Summaries are pure functions of the source flags, so they cannot be
   // written and fall as soon as their last source is cleared.
   always_comb begin
      input_any = inuv_flag[0] || src.input_other;
      vout_any = |vout_flags;
      status_byte = 8'h00;
      status_byte[SB_OFF] = !src.conv_enabled;
      status_byte[SB_OVF] = vout_flags[VF_OVF];
      status_byte[SB_OCF] = src.iout_fault;
      status_byte[SB_TEMP] = src.temp_any;
      status_byte[SB_CML] = src.cml_any;
      status_byte[SB_OTHER] = (|vout_flags[VF_OVW:VF_TONTO]) ||
         src.iout_warn || input_any || src.mfr_overtemp ||
         src.mfr_vout_min;
      word_high = 8'h00;
      word_high[SW_VOUT] = vout_any;
      word_high[SW_IOUT] = src.iout_fault || src.iout_warn;
      word_high[SW_INPUT] = input_any;
      word_high[SW_VENDOR] = src.mfr_overtemp || src.mfr_vout_min;
      word_high[SW_PNG] = src.power_bad;
   end

   // Alert sources are the flags themselves; the summary bits are left out,
   // so only a source mask can keep a fault off the alert line.
   assign alert_src = {vout_flags, src.iout_fault, src.iout_warn,
                       src.power_bad, inuv_flag[0], ext_alert};
   assign alert_mask = {vout_mask, iout_mask, png_mask_ff, inuv_mask,
                        1'b0};

   pss_alert #(
      .W(AS_NSRC)
   ) u_alert (
      .clock(clock),
      .sys_rst(sys_rst),
      .src(alert_src),
      .mask(alert_mask),
      .alert_ff(alert_ff)
   );

   always_comb begin
      nxt_rsp = '0;
      nxt_rsp.valid = cmd.valid;
      if (is_read(cmd, CMD_STATUS_BYTE)) begin
         nxt_rsp.len = LEN_BYTE;
         nxt_rsp.data = {8'h00, status_byte};
      end else if (is_read(cmd, CMD_STATUS_WORD)) begin
         nxt_rsp.len = LEN_WORD;
         nxt_rsp.data = {word_high, status_byte};
      end else if (is_read(cmd, CMD_OUTPUT_VOLTAGE_STATUS)) begin
         nxt_rsp.len = LEN_BYTE;
         nxt_rsp.data = {8'h00, vout_flags, 2'b00};
      end else if (cmd.valid && cmd.write &&
                   (cmd.code == CMD_STATUS_BYTE ||
                    cmd.code == CMD_STATUS_WORD ||
                    cmd.code == CMD_OUTPUT_VOLTAGE_STATUS)) begin
         nxt_rsp.len = 2'h0;
      end else if (cmd.valid) begin
         nxt_rsp.err = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff <= nxt_rsp;
      end
   end

   // A registered copy of the flag byte lets the power stage read it
   // without a combinational path back into this block.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         vout_status_ff <= 8'h00;
      end else begin
         vout_status_ff <= {vout_flags, 2'b00};
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   byte_read_a: assert property (
      is_read(cmd, CMD_STATUS_BYTE) |=> rsp_ff.valid &&
      rsp_ff.len == LEN_BYTE && rsp_ff.data[15:8] == 8'h00 &&
      rsp_ff.data[7:0] == $past(status_byte))
      else $error("summary byte read answered wrongly");

   off_bit_a: assert property (
      is_read(cmd, CMD_STATUS_BYTE) && !src.conv_enabled |=>
      rsp_ff.data[SB_OFF])
      else $error("off bit clear while converter disabled");

   ovf_mirror_a: assert property (
      is_read(cmd, CMD_STATUS_WORD) |=>
      rsp_ff.data[SB_OVF] == $past(vout_flags[VF_OVF]) &&
      rsp_ff.data[8 + SW_VOUT] == $past(|vout_flags))
      else $error("overvoltage summary does not follow its flag");

   ocf_mirror_a: assert property (
      is_read(cmd, CMD_STATUS_BYTE) |=>
      rsp_ff.data[SB_OCF] == $past(src.iout_fault))
      else $error("overcurrent summary does not follow its source");

   summary_nowrite_a: assert property (
      cmd.valid && cmd.write && (cmd.code == CMD_STATUS_BYTE ||
      cmd.code == CMD_STATUS_WORD) &&
      vout_evt == '0 |=> $stable(vout_flags) && !rsp_ff.err)
      else $error("summary write changed state");

   word_low_a: assert property (
      is_read(cmd, CMD_STATUS_WORD) |=> rsp_ff.len == LEN_WORD &&
      rsp_ff.data[7:0] == $past(status_byte) &&
      rsp_ff.data[10:8] == 3'h0)
      else $error("word low byte differs from summary byte");

   w1c_clear_a: assert property (
      vout_clr && cmd.wdata[7] && !vout_evt[VF_OVF] |=>
      !vout_flags[VF_OVF] ##1 !vout_status_ff[7])
      else $error("overvoltage flag not cleared by write");

   set_wins_a: assert property (
      vout_evt[VF_UVW] |=> vout_flags[VF_UVW])
      else $error("undervoltage warning event lost");

   alert_a: assert property (
      |(alert_src & ~alert_mask) |=> alert_ff)
      else $error("alert not raised for unmasked source");

   no_alert_a: assert property (
      alert_src == alert_mask && alert_src != '0 && !ext_alert |=> !alert_ff)
      else $error("alert raised with every source masked");

   png_mask_a: assert property (
      $fell(sys_rst) |-> png_mask_ff && status_byte[SB_OTHER])
      else $error("reset values of mask or other bit wrong");

   vout_read_a: assert property (
      is_read(cmd, CMD_OUTPUT_VOLTAGE_STATUS) |=> rsp_ff.data[1:0] == 2'b00 &&
      rsp_ff.data[7:2] == $past(vout_flags))
      else $error("output-voltage status read wrong");

   temp_bit_a: assert property (
      status_byte[SB_TEMP] == src.temp_any)
      else $error("temperature summary bit wrong");

   cml_bit_a: assert property (
      status_byte[SB_CML] == src.cml_any)
      else $error("communication summary bit wrong");

   other_set_a: assert property (
      src.iout_warn || vout_flags[VF_UVF] |-> status_byte[SB_OTHER])
      else $error("other summary bit clear with warning present");

   other_clear_a: assert property (
      vout_flags == '0 && !src.iout_warn && !input_any &&
      !src.mfr_overtemp && !src.mfr_vout_min |-> !status_byte[SB_OTHER])
      else $error("other summary bit set with no source");

   inuv_reset_a: assert property (
      $fell(sys_rst) |-> inuv_flag[0])
      else $error("input undervoltage flag not set after reset");

   vout_sum_set_a: assert property (
      vout_flags[VF_SETPT] || vout_flags[VF_TONTO] |-> word_high[SW_VOUT])
      else $error("output-voltage summary misses a flag");

   vout_sum_clr_a: assert property (
      vout_flags == '0 |-> !word_high[SW_VOUT])
      else $error("output-voltage summary set with no flag");

   iout_sum_a: assert property (
      src.iout_warn |-> word_high[SW_IOUT])
      else $error("output-current summary misses warning");

   input_sum_a: assert property (
      inuv_flag[0] |-> word_high[SW_INPUT])
      else $error("input summary misses undervoltage flag");

   vendor_sum_a: assert property (
      src.mfr_vout_min |-> word_high[SW_VENDOR])
      else $error("vendor summary misses output minimum warning");

   png_track_a: assert property (
      !src.power_bad |-> !word_high[SW_PNG])
      else $error("power-not-good bit held after condition left");

   png_read_a: assert property (
      is_read(cmd, CMD_STATUS_WORD) && src.power_bad |=>
      rsp_ff.data[8 + SW_PNG])
      else $error("power-not-good bit missing from word read");

   unused_bits_a: assert property (
      !status_byte[7] && !status_byte[3] && word_high[2:0] == 3'h0)
      else $error("unused summary bits not zero");

   vout_reg_a: assert property (
      1'b1 |=> vout_status_ff == {$past(vout_flags), 2'b00})
      else $error("registered output-voltage byte wrong");

   ro_write_a: assert property (
      cmd.valid && cmd.write && cmd.code == CMD_STATUS_BYTE |=>
      rsp_ff.valid && !rsp_ff.err && rsp_ff.len == 2'h0)
      else $error("write to summary byte not ignored quietly");

   unknown_err_a: assert property (
      cmd.valid && cmd.code != CMD_STATUS_BYTE && cmd.code !=
      CMD_STATUS_WORD && cmd.code != CMD_OUTPUT_VOLTAGE_STATUS |=> rsp_ff.err)
      else $error("unserved command not flagged");

   rsp_idle_a: assert property (
      !cmd.valid |=> rsp_ff == '0)
      else $error("answer shown without a command");

   clr_race_a: assert property (
      vout_clr && cmd.wdata[7] && vout_evt[VF_OVF] |=> vout_flags[VF_OVF])
      else $error("overvoltage event lost to a same-cycle clear");

   clr_keep_a: assert property (
      vout_clr && !cmd.wdata[VOUT_LSB + VF_OVW] && vout_flags[VF_OVW] |=>
      vout_flags[VF_OVW])
      else $error("flag cleared by a write of zero");

   alert_low_a: assert property (
      (alert_src & ~alert_mask) == '0 |=> !alert_ff)
      else $error("alert raised with no unmasked source");

   cover_clear_c: cover property (vout_clr ##1 vout_flags == '0);
   cover_word_c: cover property (is_read(cmd, CMD_STATUS_WORD) ##1
      rsp_ff.data[8 + SW_PNG]);
   cover_alert_c: cover property ($rose(alert_ff));
   cover_race_c: cover property (vout_clr && vout_evt[VF_OVF]);

endmodule // pss_status

// *** pss_host_model.sv ***
module pss_host_model
   import pss_pkg::*;
(
   input wire logic clock,
   input pss_rsp_s rsp_ff,
   output pss_cmd_s cmd
);
   timeunit 1ns;
   timeprecision 1ps;

   initial cmd = '0;

   // One command, taken at the next rising edge, then a bounded wait for
   // the answer. Released fields show inverted values so that a stale code
   // is never mistaken for a held one.
   task automatic xfer(input logic w, input logic [7:0] code,
                       input logic [7:0] wd, output logic [15:0] data,
                       output logic [1:0] len, output logic err,
                       output logic ok);
      int n;
      ok = 1'b0;
      data = '0;
      len = '0;
      err = 1'b0;
      @(negedge clock);
      cmd <= '{valid: 1'b1, write: w, code: code, wdata: wd};
      @(negedge clock);
      cmd <= '{valid: 1'b0, write: ~w, code: ~code, wdata: ~wd};
      for (n = 0; n < 4 && ok == 1'b0; n++) begin
         if (rsp_ff.valid === 1'b1) begin
            data = rsp_ff.data;
            len = rsp_ff.len;
            err = rsp_ff.err;
            ok = 1'b1;
         end else begin
            @(negedge clock);
         end
      end
   endtask
endmodule // pss_host_model

// *** pss_status_tb_top.sv ***
module pss_status_tb_top
   import pss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   pss_cmd_s cmd;
   pss_src_s src;
   pss_rsp_s rsp_ff;
   logic [5:0] vout_evt, vout_mask;
   logic [1:0] iout_mask;
   logic vin_low_evt, inuv_clr, inuv_mask, ext_alert;
   logic png_mask_wr, png_mask_val, alert_ff;
   logic [7:0] vout_status_ff;
   logic [15:0] rd_data, exp_w;
   logic [1:0] rd_len;
   logic rd_err;
   int n_fail = 0;
   int tests_run = 0;
   // Source patterns with the word and alert level each one must give.
   logic [8:0] t_src [9] = '{9'h000, 9'h180, 9'h140, 9'h120, 9'h110,
                             9'h108, 9'h104, 9'h102, 9'h101};
   logic [15:0] t_word [9] = '{16'h0040, 16'h4010, 16'h4001, 16'h0004,
                               16'h0002, 16'h2001, 16'h1001, 16'h1001,
                               16'h0800};
   logic [15:0] t_alert [9] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'h0,
                                16'h0, 16'h0, 16'h0, 16'h0};

   always #20 clock = ~clock;

   pss_host_model i_pss_host_model (.clock(clock), .rsp_ff(rsp_ff),
                                    .cmd(cmd));

   pss_status i_pss_status (.clock(clock), .sys_rst(sys_rst), .cmd(cmd),
      .src(src), .vout_evt(vout_evt), .vout_mask(vout_mask),
      .iout_mask(iout_mask), .vin_low_evt(vin_low_evt),
      .inuv_clr(inuv_clr), .inuv_mask(inuv_mask), .ext_alert(ext_alert),
      .png_mask_wr(png_mask_wr), .png_mask_val(png_mask_val),
      .rsp_ff(rsp_ff), .vout_status_ff(vout_status_ff),
      .alert_ff(alert_ff));

   task automatic summarize();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] seen,
                      input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cmd_io(input logic w, input logic [7:0] code,
                         input logic [7:0] wd);
      logic ok;
      i_pss_host_model.xfer(w, code, wd, rd_data, rd_len, rd_err, ok);
      if (ok !== 1'b1) begin
         n_fail++;
         summarize();
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask

   initial begin
      src = pss_src_s'(9'h100);
      vout_evt = '0;
      vout_mask = 6'h15;
      iout_mask = 2'h1;
      {vin_low_evt, inuv_clr, inuv_mask, ext_alert} = '0;
      {png_mask_wr, png_mask_val} = '0;
      tick(6);
      sys_rst = 1'b0;
      cmd_io(1'b0, CMD_STATUS_BYTE, 8'h00);
      chk("byte after reset", rd_data, 16'h0001);
      chk("byte len", {14'h0, rd_len}, {14'h0, LEN_BYTE});
      cmd_io(1'b0, CMD_STATUS_WORD, 8'h00);
      chk("word after reset", rd_data, 16'h2001);
      chk("word len", {14'h0, rd_len}, {14'h0, LEN_WORD});
      cmd_io(1'b0, CMD_OUTPUT_VOLTAGE_STATUS, 8'h00);
      chk("vout after reset", rd_data, 16'h0000);
      chk("alert after reset", {15'h0, alert_ff}, 16'h1);
      inuv_clr = 1'b1;
      tick(1);
      inuv_clr = 1'b0;
      tick(2);
      cmd_io(1'b0, CMD_STATUS_WORD, 8'h00);
      chk("word idle", rd_data, 16'h0000);
      chk("alert idle", {15'h0, alert_ff}, 16'h0);
      for (int k = 0; k < 9; k++) begin
         src = pss_src_s'(t_src[k]);
         cmd_io(1'b0, CMD_STATUS_WORD, 8'h00);
         chk("word per source", rd_data, t_word[k]);
         cmd_io(1'b0, CMD_STATUS_BYTE, 8'h00);
         chk("byte per source", rd_data, {8'h00, t_word[k][7:0]});
         chk("alert per source", {15'h0, alert_ff}, t_alert[k]);
      end
      src = pss_src_s'(9'h101);
      png_mask_wr = 1'b1;
      tick(1);
      png_mask_wr = 1'b0;
      tick(2);
      chk("alert power bad", {15'h0, alert_ff}, 16'h1);
      src = pss_src_s'(9'h100);
      tick(2);
      chk("alert power good", {15'h0, alert_ff}, 16'h0);
      ext_alert = 1'b1;
      tick(2);
      chk("alert external", {15'h0, alert_ff}, 16'h1);
      ext_alert = 1'b0;
      for (int i = 0; i < 6; i++) begin
         vout_evt[i] = 1'b1;
         tick(1);
         vout_evt = '0;
         tick(2);
         cmd_io(1'b0, CMD_OUTPUT_VOLTAGE_STATUS, 8'h00);
         chk("vout flag", rd_data, 16'h0001 << (i + 2));
         chk("vout reg", {8'h00, vout_status_ff}, 16'h0001 << (i + 2));
         chk("alert vout", {15'h0, alert_ff}, {15'h0, ~vout_mask[i]});
         cmd_io(1'b1, CMD_STATUS_WORD, 8'hff);
         chk("ro write", {13'h0, rd_err, rd_len}, 16'h0);
         exp_w = (i == 5) ? 16'h8020 : 16'h8001;
         cmd_io(1'b0, CMD_STATUS_WORD, 8'h00);
         chk("word vout", rd_data, exp_w);
         cmd_io(1'b1, CMD_OUTPUT_VOLTAGE_STATUS, 8'h01 << (i + 2));
         tick(2);
         cmd_io(1'b0, CMD_STATUS_WORD, 8'h00);
         chk("word cleared", rd_data, 16'h0000);
         chk("alert cleared", {15'h0, alert_ff}, 16'h0);
      end
      cmd_io(1'b0, 8'h00, 8'h00);
      chk("unknown code", {rd_err, rd_len, rd_data[12:0]}, 16'h8000);
      vin_low_evt = 1'b1;
      tick(1);
      vin_low_evt = 1'b0;
      tick(2);
      cmd_io(1'b0, CMD_STATUS_BYTE, 8'h00);
      chk("byte undervolt", rd_data, 16'h0001);
      chk("alert undervolt", {15'h0, alert_ff}, 16'h1);
      summarize();
   end
endmodule // pss_status_tb_top
